// file: pkg/wtu_pkg.sv
// constants, types and behaviour summary of the watchdog timer unit
// What this block does
// [RULE1] The watchdog is an 11-bit prescaler feeding an 8-bit up-counter that software sees as watchdog_count.
// [RULE2] The prescaler advances once per cycle of the dedicated watchdog oscillator (nominal 1 MHz, +100%/-50%).
// [RULE3] watchdog_count increments once every 2048 oscillator cycles, each time the prescaler wraps.
// [RULE4] An overflow of watchdog_count while enabled resets the chip and drives a 16x2048-cycle pulse on the reset pin.
// [RULE5] The internal watchdog reset is raised even while an outside circuit holds the reset pin low.
// [RULE6] Any reset loads watchdog_control with a5; while it holds a5 the oscillator stops and both counters stay clear (code runs it during the reset pulse).
// [RULE7] Any watchdog_control value other than a5 runs the oscillator and enables the watchdog.
// [RULE8] Software may read watchdog_count at any time while it counts, without stopping it.
// [RULE9] A write to watchdog_count takes effect only while watchdog_control holds 5a, and is ignored otherwise.
// [RULE10] An accepted count write clears the prescaler and clears watchdog_control to zero, locking further writes.
// [RULE11] Oscillator increments are blocked during any software read or write of watchdog_count.
// [RULE12] The timeout is (256 - loaded count) x 2048 divided by the oscillator frequency.
// [RULE13] Software must write 5a to watchdog_control and reload watchdog_count before the timeout expires.
// [RULE14] Oscillator increments are synchronised into the system clock domain before they touch the count.
package wtu_pkg;

    // register space
    localparam logic [7:0] WTU_ADDR_CONTROL = 8'ha5;
    localparam logic [7:0] WTU_ADDR_COUNT = 8'hff;
    localparam logic [7:0] WTU_CONTROL_RESET = 8'ha5;
    localparam logic [7:0] WTU_COUNT_RESET = 8'h00;
    localparam logic [7:0] WTU_CONTROL_HALT = 8'ha5;
    localparam logic [7:0] WTU_CONTROL_UNLOCK = 8'h5a;
    localparam logic [7:0] WTU_CONTROL_LOCKED = 8'h00;
    localparam logic [7:0] WTU_RDATA_RESET = 8'h00;

    // widths
    localparam int WTU_PRESCALE_BITS = 11;
    localparam int WTU_COUNT_BITS = 8;
    localparam int WTU_PULSE_BITS = 16;

    // timing
    localparam int WTU_OSC_FREQ_HZ = 1000000;
    localparam int WTU_OSC_PER_COUNT = 2048;
    localparam int WTU_PULSE_MULT = 16;
    localparam int WTU_PULSE_OSC_CYCLES = WTU_PULSE_MULT * WTU_OSC_PER_COUNT;
    localparam int WTU_SYS_FREQ_HZ = 40000000;
    localparam int WTU_SYNC_STAGES = 2;

    // special-function-register access from the core
    typedef struct packed {
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } wtu_sfr_req_s;

    // reset pin drive (open drain, low only)
    typedef struct packed {
        logic out;
        logic oe;
    } wtu_pin_drv_s;

    typedef enum logic [0:0] {
        WTU_ST_RUN = 1'b0,
        WTU_ST_PULSE = 1'b1
    } wtu_state_e;

    // timeout in oscillator cycles for a loaded count
    function automatic int wtu_timeout_osc_cycles(input logic [7:0] loaded);
        wtu_timeout_osc_cycles = (256 - int'(loaded)) * WTU_OSC_PER_COUNT; // RULE12
    endfunction : wtu_timeout_osc_cycles

endpackage : wtu_pkg

// file: src/wtu_osc_sync.sv
// two-stage synchroniser and rising edge detect for the watchdog oscillator
`timescale 1ns/10ps
module wtu_osc_sync
    import wtu_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // oscillator pin
    input wire logic osc_in,
    // one-cycle pulse per oscillator rising edge
    output logic osc_tick
);

    logic [WTU_SYNC_STAGES-1:0] sync_q;
    logic last_q;

    // two flops before any logic reads the pin
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sync_q <= '0;
        end
        else
        begin
            sync_q <= {sync_q[WTU_SYNC_STAGES-2:0], osc_in}; // RULE14
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            last_q <= 1'b0;
        end
        else
        begin
            last_q <= sync_q[WTU_SYNC_STAGES-1];
        end
    end

    assign osc_tick = sync_q[WTU_SYNC_STAGES-1] & ~last_q;

endmodule : wtu_osc_sync

// file: src/wtu_watchdog.sv
// watchdog timer unit: prescaler, count, control register and reset pulse
`timescale 1ns/10ps
module wtu_watchdog
    import wtu_pkg::*;
#(
    parameter int PULSE_OSC_CYCLES = WTU_PULSE_OSC_CYCLES
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,

    // dedicated watchdog oscillator
    input wire logic osc_in,
    output logic osc_run_q,

    // special-function-register access
    input wire wtu_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata_q,

    // chip reset request and reset pin drive
    output logic wd_reset_q,
    output wtu_pin_drv_s rst_pin_q
);

    localparam logic [WTU_PULSE_BITS-1:0] PULSE_LAST = WTU_PULSE_BITS'(PULSE_OSC_CYCLES - 1);
    localparam logic [WTU_PRESCALE_BITS-1:0] PRESCALE_LAST = WTU_PRESCALE_BITS'(WTU_OSC_PER_COUNT - 1);
    localparam logic [WTU_COUNT_BITS-1:0] COUNT_LAST = {WTU_COUNT_BITS{1'b1}};

    // registers
    logic [7:0] control_q;
    logic [WTU_COUNT_BITS-1:0] count_q;
    logic [WTU_PRESCALE_BITS-1:0] prescale_q;
    logic [WTU_PULSE_BITS-1:0] pulse_cnt_q;
    wtu_state_e state_q;

    // reset pin flops
    logic pin_out_q;
    logic pin_oe_q;

    // decoded access
    logic count_sel;
    logic control_sel;
    logic count_access;
    logic count_wr;
    logic count_wr_ok;
    logic control_wr;
    logic count_rd;
    logic control_rd;

    // oscillator-derived events
    logic osc_tick;
    logic enabled;
    logic count_tick;
    logic prescale_wrap;
    logic overflow;
    logic pulse_tick;
    logic pulse_done;
    logic in_pulse;

    wtu_osc_sync u_sync
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .osc_in(osc_in),
        .osc_tick(osc_tick)
    );

    // register decode
    assign count_sel = (sfr_req.addr == WTU_ADDR_COUNT);
    assign control_sel = (sfr_req.addr == WTU_ADDR_CONTROL);
    assign count_access = count_sel & (sfr_req.rd | sfr_req.wr);
    assign count_wr = count_sel & sfr_req.wr;
    assign count_wr_ok = count_wr & (control_q == WTU_CONTROL_UNLOCK); // RULE9
    assign control_wr = control_sel & sfr_req.wr;

    // read decode
    assign count_rd = count_sel & sfr_req.rd;
    assign control_rd = control_sel & sfr_req.rd;

    // watchdog enable
    assign enabled = (control_q != WTU_CONTROL_HALT); // RULE7

    // chip held in reset while the pulse runs
    assign in_pulse = (state_q == WTU_ST_PULSE);

    // increments, suppressed during a count access
    assign count_tick = osc_tick & enabled & ~count_access & (state_q == WTU_ST_RUN); // RULE2 RULE11
    assign prescale_wrap = count_tick & (prescale_q == PRESCALE_LAST); // RULE3
    assign overflow = prescale_wrap & (count_q == COUNT_LAST); // RULE4

    // pulse timing on the oscillator
    assign pulse_tick = osc_tick & (state_q == WTU_ST_PULSE);
    assign pulse_done = pulse_tick & (pulse_cnt_q == PULSE_LAST);

    // control register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            control_q <= WTU_CONTROL_RESET; // RULE6
        end
        else if (overflow || in_pulse)
        begin
            control_q <= WTU_CONTROL_RESET; // RULE6
        end
        else if (count_wr_ok)
        begin
            control_q <= WTU_CONTROL_LOCKED; // RULE10
        end
        else if (control_wr)
        begin
            control_q <= sfr_req.wdata;
        end
    end

    // prescaler
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            prescale_q <= '0;
        end
        else if (!enabled || overflow || count_wr_ok)
        begin
            prescale_q <= '0; // RULE6 RULE10
        end
        else if (count_tick)
        begin
            prescale_q <= prescale_q + 1'b1; // RULE1 RULE2
        end
    end

    // watchdog count
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            count_q <= WTU_COUNT_RESET;
        end
        else if (overflow)
        begin
            count_q <= WTU_COUNT_RESET;
        end
        else if (count_wr_ok)
        begin
            count_q <= sfr_req.wdata; // RULE9 RULE12
        end
        else if (!enabled)
        begin
            count_q <= WTU_COUNT_RESET; // RULE6
        end
        else if (prescale_wrap)
        begin
            count_q <= count_q + 1'b1; // RULE1 RULE3
        end
    end

    // reset pulse sequence
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_q <= WTU_ST_RUN;
        end
        else
        begin
            unique case (state_q)
                WTU_ST_RUN:
                begin
                    if (overflow)
                    begin
                        state_q <= WTU_ST_PULSE; // RULE4
                    end
                end
                WTU_ST_PULSE:
                begin
                    if (pulse_done)
                    begin
                        state_q <= WTU_ST_RUN;
                    end
                end
            endcase
        end
    end

    // pulse length counter in oscillator cycles
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pulse_cnt_q <= '0;
        end
        else if (overflow || pulse_done)
        begin
            pulse_cnt_q <= '0;
        end
        else if (pulse_tick)
        begin
            pulse_cnt_q <= pulse_cnt_q + 1'b1; // RULE4
        end
    end

    // internal chip reset, not gated by the pin level
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wd_reset_q <= 1'b0;
        end
        else if (overflow)
        begin
            wd_reset_q <= 1'b1; // RULE4 RULE5
        end
        else if (pulse_done)
        begin
            wd_reset_q <= 1'b0;
        end
    end

    // reset pin: open drain, pulled low during the pulse
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_out_q <= 1'b0;
        end
        else
        begin
            pin_out_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_oe_q <= 1'b0;
        end
        else if (overflow)
        begin
            pin_oe_q <= 1'b1; // RULE4
        end
        else if (pulse_done)
        begin
            pin_oe_q <= 1'b0;
        end
    end

    // pin drive straight from its flops
    assign rst_pin_q = '{out: pin_out_q, oe: pin_oe_q};

    // oscillator run request, kept on while the pulse is timed
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            osc_run_q <= 1'b0; // RULE6
        end
        else if (overflow)
        begin
            osc_run_q <= 1'b1;
        end
        else if (state_q == WTU_ST_PULSE && !pulse_done)
        begin
            osc_run_q <= 1'b1;
        end
        else if (count_wr_ok)
        begin
            osc_run_q <= 1'b1; // RULE10
        end
        else if (control_wr)
        begin
            osc_run_q <= (sfr_req.wdata != WTU_CONTROL_HALT); // RULE7
        end
        else
        begin
            osc_run_q <= enabled; // RULE6 RULE7
        end
    end

    // read data, count read on the fly
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sfr_rdata_q <= WTU_RDATA_RESET;
        end
        else if (count_rd)
        begin
            sfr_rdata_q <= count_q; // RULE8
        end
        else if (control_rd)
        begin
            sfr_rdata_q <= control_q;
        end
        else if (sfr_req.rd)
        begin
            sfr_rdata_q <= WTU_RDATA_RESET;
        end
    end

endmodule : wtu_watchdog

// file: test/wtu_watchdog_monitor.sv
// port assertions for the watchdog timer unit
`timescale 1ns/10ps
module wtu_watchdog_monitor
    import wtu_pkg::*;
#(
    parameter int PULSE_OSC_CYCLES = WTU_PULSE_OSC_CYCLES
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // oscillator
    input wire logic osc_in,
    input wire logic osc_run_q,
    // register access
    input wire wtu_sfr_req_s sfr_req,
    input wire logic [7:0] sfr_rdata_q,
    // reset outputs
    input wire logic wd_reset_q,
    input wire wtu_pin_drv_s rst_pin_q
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic rd_ctl;
    logic rd_cnt;
    assign rd_ctl = sfr_req.rd && sfr_req.addr == WTU_ADDR_CONTROL;
    assign rd_cnt = sfr_req.rd && sfr_req.addr == WTU_ADDR_COUNT;
    pin_low_a: assert property (rst_pin_q.oe |-> rst_pin_q.out == 1'b0)
        else $error("reset pin driven high");
    pulse_pair_a: assert property (wd_reset_q == rst_pin_q.oe)
        else $error("internal reset and pin drive differ");
    pulse_osc_a: assert property (wd_reset_q |-> osc_run_q)
        else $error("oscillator stopped in reset pulse");
    pulse_len_a: assert property ($rose(wd_reset_q) |=> wd_reset_q [*8])
        else $error("reset pulse too short");
    rdata_hold_a: assert property (!sfr_req.rd |=> $stable(sfr_rdata_q))
        else $error("read data changed without read");
    halted_a: assert property (!osc_run_q && !wd_reset_q |=> !wd_reset_q)
        else $error("pulse started while halted");
    ctl_pulse_a: assert property (wd_reset_q && rd_ctl |=> sfr_rdata_q == WTU_CONTROL_HALT)
        else $error("control not reloaded on overflow");
    cnt_pulse_a: assert property (wd_reset_q && rd_cnt |=> sfr_rdata_q == WTU_COUNT_RESET)
        else $error("count not cleared on overflow");
    unmapped_a: assert property (sfr_req.rd && !rd_ctl && !rd_cnt |=> sfr_rdata_q == WTU_RDATA_RESET)
        else $error("unmapped read not zero");
    cover property ($rose(wd_reset_q));
    cover property (wd_reset_q && rd_ctl);
    cover property ($fell(osc_run_q));
endmodule : wtu_watchdog_monitor

bind wtu_watchdog wtu_watchdog_monitor #(.PULSE_OSC_CYCLES(PULSE_OSC_CYCLES)) mon_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .osc_in(osc_in),
    .osc_run_q(osc_run_q),
    .sfr_req(sfr_req),
    .sfr_rdata_q(sfr_rdata_q),
    .wd_reset_q(wd_reset_q),
    .rst_pin_q(rst_pin_q)
);

// file: test/watchdog_timer_unit_tb_top.sv
// self-checking bench for the watchdog timer unit
`timescale 1ns/10ps
module watchdog_timer_unit_tb_top
    import wtu_pkg::*;
();
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic osc_in = 1'b0;
    logic osc_run_q;
    logic wd_reset_q;
    logic [7:0] sfr_rdata_q;
    wtu_sfr_req_s req = '0;
    wtu_pin_drv_s pin;
    logic [7:0] exp_q[$];
    logic rd_taken = 1'b0;
    logic [7:0] r;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t0;
    int seed = 33297;

    always #12.5 sys_clk = ~sys_clk;

    wtu_watchdog #(.PULSE_OSC_CYCLES(4)) dut_u (
        .sys_clk(sys_clk),
        .rst(rst),
        .osc_in(osc_in),
        .osc_run_q(osc_run_q),
        .sfr_req(req),
        .sfr_rdata_q(sfr_rdata_q),
        .wd_reset_q(wd_reset_q),
        .rst_pin_q(pin)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask : check

    task print_verdict;
        if (err_total == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    // one access, strobe held for one edge
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        req.addr <= a;
        req.rd <= !w;
        req.wr <= w;
        req.wdata <= d;
        @(posedge sys_clk);
        req.rd <= 1'b0;
        req.wr <= 1'b0;
        @(posedge sys_clk);
    endtask : acc

    task rd(input logic [7:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        acc(1'b0, a, 8'h00);
    endtask : rd

    // oscillator of period 4 cycles, only while run is requested
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc[0])
            osc_in <= osc_run_q & ~osc_in;
        if (cyc == 40000)
        begin
            err_total++;
            print_verdict();
        end
    end

    // read results compared one cycle after the strobe
    always @(posedge sys_clk)
        rd_taken <= req.rd;
    always @(negedge sys_clk)
        if (rd_taken)
            check(sfr_rdata_q, exp_q.pop_front());

    initial
    begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(WTU_ADDR_CONTROL, WTU_CONTROL_RESET);
        rd(WTU_ADDR_COUNT, WTU_COUNT_RESET);
        r = 8'($random(seed));
        if (r == WTU_ADDR_CONTROL || r == WTU_ADDR_COUNT)
            r = 8'h10;
        rd(r, WTU_RDATA_RESET);
        @(negedge sys_clk);
        check({7'h00, osc_run_q}, 8'h00);
        @(posedge sys_clk);
        acc(1'b1, WTU_ADDR_COUNT, 8'($random(seed)));
        rd(WTU_ADDR_COUNT, WTU_COUNT_RESET);
        acc(1'b1, WTU_ADDR_CONTROL, WTU_CONTROL_UNLOCK);
        acc(1'b1, WTU_ADDR_COUNT, 8'hfe);
        t0 = cyc;
        rd(WTU_ADDR_CONTROL, WTU_CONTROL_LOCKED);
        rd(WTU_ADDR_COUNT, 8'hfe);
        acc(1'b1, WTU_ADDR_COUNT, 8'($random(seed)));
        rd(WTU_ADDR_COUNT, 8'hfe);
        @(negedge sys_clk);
        check({7'h00, osc_run_q}, 8'h01);
        @(posedge sys_clk);
        while (wd_reset_q !== 1'b1)
            @(posedge sys_clk);
        @(negedge sys_clk);
        // two counts of 2048 ticks, 4 cycles each, few ticks lost to reads
        check({7'h00, cyc - t0 >= 16380 && cyc - t0 <= 16404}, 8'h01);
        check({6'h00, pin.oe, pin.out}, 8'h02);
        t0 = cyc;
        @(posedge sys_clk);
        rd(WTU_ADDR_CONTROL, WTU_CONTROL_HALT);
        rd(WTU_ADDR_COUNT, WTU_COUNT_RESET);
        // control write while the chip is held in reset
        acc(1'b1, WTU_ADDR_CONTROL, WTU_CONTROL_UNLOCK);
        rd(WTU_ADDR_CONTROL, WTU_CONTROL_HALT);
        while (wd_reset_q === 1'b1)
            @(posedge sys_clk);
        @(negedge sys_clk);
        check({7'h00, cyc - t0 >= 12 && cyc - t0 <= 20}, 8'h01);
        check({7'h00, pin.oe}, 8'h00);
        repeat (3) @(negedge sys_clk);
        check({7'h00, osc_run_q}, 8'h00);
        @(posedge sys_clk);
        r = 8'($random(seed));
        if (r == WTU_CONTROL_HALT)
            r = 8'h00;
        acc(1'b1, WTU_ADDR_CONTROL, r);
        repeat (8) @(negedge sys_clk);
        check({7'h00, osc_run_q}, 8'h01);
        @(posedge sys_clk);
        acc(1'b1, WTU_ADDR_CONTROL, WTU_CONTROL_HALT);
        repeat (3) @(negedge sys_clk);
        check({7'h00, osc_run_q}, 8'h00);
        @(posedge sys_clk);
        rd(WTU_ADDR_COUNT, WTU_COUNT_RESET);
        repeat (2) @(posedge sys_clk);
        print_verdict();
    end
endmodule : watchdog_timer_unit_tb_top
